// ### rtl/sac_cluster.sv
// Purpose: ten-cell cluster wired for shared arithmetic chains
// Assumes: ref_clk is the global clock; cluster clock is gated by its enable
// Notes: chain link ports join neighbouring clusters in one column
`timescale 1ns/1ps
module sac_cluster #(
    parameter int CELLS = sac_pkg::CELLS,
    parameter logic BYPASS_TOP_COLUMN = 1'h1
) (
    // clocks and clears
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic device_wide_clear_n,
    input wire logic cluster_clock_enable_one,
    input wire logic [sac_pkg::CLEAR_LINES-1:0] clusterClr,
    input wire logic [2*CELLS-1:0] clrSel,
    // synchronous controls
    input wire logic sclr,
    input wire logic sload,
    input wire logic [2*CELLS-1:0] sclrUse,
    input wire logic [2*CELLS-1:0] sloadUse,
    input wire logic [2*CELLS-1:0] loadData,
    input wire logic [2*CELLS-1:0] presetInv,
    // chain configuration
    input wire logic startFirst,
    input wire logic startSixth,
    input wire logic halfBypass,
    input wire logic [CELLS-1:0] cellActive,
    input wire logic [CELLS-1:0] regChainSel,
    // operands
    input wire logic [2*CELLS-1:0] opA,
    input wire logic [2*CELLS-1:0] opB,
    input wire logic [2*CELLS-1:0] opC,
    // links to the cluster above and below
    input wire logic shareLinkIn,
    input wire logic carryLinkIn,
    input wire logic regLinkIn,
    output logic shareLinkOut,
    output logic carryLinkOut,
    output logic regLinkOut,
    // results
    output logic [2*CELLS-1:0] sumComb,
    output logic [2*CELLS-1:0] sumReg
);
    // ************************************************************
    // gated cluster clock
    // ************************************************************
    // enable latched while clock low keeps the gated clock glitch free
    logic enLatch;
    always_latch begin
        if (!ref_clk) begin
            enLatch = cluster_clock_enable_one;
        end
    end
    wire logic clusterClockOne = ref_clk & enLatch;

    // ************************************************************
    // device clear synchronised on release
    // ************************************************************
    // release stays two edges late so no register sees a runt clear
    logic clrSync1;
    logic clrSync2;
    wire logic clrIn = resetn & device_wide_clear_n;
    always_ff @(posedge ref_clk or negedge clrIn) begin
        if (!clrIn) begin
            clrSync1 <= 1'h0;
            clrSync2 <= 1'h0;
        end else begin
            clrSync1 <= 1'h1;
            clrSync2 <= clrSync1;
        end
    end
    // assertion is immediate, only release waits for the synchroniser
    wire logic devClrN = clrIn & clrSync2;

    // ************************************************************
    // chain start, half bypass and inter-cell links
    // ************************************************************
    // top half is cells 0..4; which half may be skipped alternates by column
    wire logic skipTop = halfBypass & BYPASS_TOP_COLUMN;
    wire logic skipBot = halfBypass & !BYPASS_TOP_COLUMN;
    wire logic [CELLS-1:0] shareIn;
    wire logic [CELLS-1:0] carryIn;
    wire logic [CELLS-1:0] shareOut;
    wire logic [CELLS-1:0] carryOut;
    wire logic [2*CELLS-1:0] regQ;
    wire logic [2*CELLS-1:0] regIn;
    // link input enters at cell 0, or at cell 5 when top half is skipped
    wire logic linkAtSixth = skipTop;
    wire logic [CELLS-1:0] cellUsed;
    // one entry select for both terms keeps share and carry starts in step
    function automatic logic entryTerm(input logic fresh, input logic fromLink,
            input logic linkTerm, input logic prevTerm);
        entryTerm = fresh ? 1'h0 : (fromLink ? linkTerm : prevTerm);
    endfunction
    genvar i;
    generate
        for (i = 0; i < CELLS; i++) begin : gCell
            localparam bit IS_TOP = (i < sac_pkg::HALF_CELLS);
            assign cellUsed[i] = cellActive[i] & !(IS_TOP ? skipTop : skipBot);
            if (i == sac_pkg::FIRST_START_CELL) begin : gS0
                // fresh chain at cell one starts with no share term
                assign shareIn[i] = entryTerm(startFirst, 1'h1, shareLinkIn, 1'h0);
                assign carryIn[i] = entryTerm(startFirst, 1'h1, carryLinkIn, 1'h0);
            end else if (i == sac_pkg::SECOND_START_CELL) begin : gS5
                // cell six takes a new start, a link past a skipped top, or cell five
                assign shareIn[i] = entryTerm(startSixth, linkAtSixth, shareLinkIn,
                    shareOut[i-1]);
                assign carryIn[i] = entryTerm(startSixth, linkAtSixth, carryLinkIn,
                    carryOut[i-1]);
            end else begin : gSn
                assign shareIn[i] = shareOut[i-1];
                assign carryIn[i] = carryOut[i-1];
            end
            // register chain: cell i bit 0 follows bit 1 of the cell above
            if (i == 0) begin : gR0
                assign regIn[1:0] = {regQ[0], regLinkIn};
            end else begin : gRn
                assign regIn[2*i+1:2*i] = {regQ[2*i], regQ[2*i-1]};
            end
            sac_cell uCell (
                .gclk(clusterClockOne),
                .devClrN(devClrN),
                .aclr(clusterClr),
                .clrSel(clrSel[2*i+1:2*i]),
                .sclr(sclr),
                .sload(sload),
                .sclrUse(sclrUse[2*i+1:2*i]),
                .sloadUse(sloadUse[2*i+1:2*i]),
                .loadData(loadData[2*i+1:2*i]),
                .presetInv(presetInv[2*i+1:2*i]),
                .active(cellUsed[i]),
                .opA(opA[2*i+1:2*i]),
                .opB(opB[2*i+1:2*i]),
                .opC(opC[2*i+1:2*i]),
                .shareIn(shareIn[i]),
                .carryIn(carryIn[i]),
                .chainSel(regChainSel[i]),
                .chainIn(regIn[2*i+1:2*i]),
                .sumComb(sumComb[2*i+1:2*i]),
                .sumReg(regQ[2*i+1:2*i]),
                .shareOut(shareOut[i]),
                .carryOut(carryOut[i])
            );
        end
    endgenerate
    assign sumReg = regQ;

    // ************************************************************
    // link outputs to the next cluster down
    // ************************************************************
    // with the bottom half skipped the chain leaves from cell five
    wire logic lastHalf = skipBot;
    assign shareLinkOut = lastHalf ? shareOut[sac_pkg::HALF_CELLS-1] : shareOut[CELLS-1];
    assign carryLinkOut = lastHalf ? carryOut[sac_pkg::HALF_CELLS-1] : carryOut[CELLS-1];
    assign regLinkOut = regQ[2*CELLS-1];
endmodule

// ### include/sac_pkg.sv
// Purpose: shared constants for the shared arithmetic cluster slice
// Assumes: one cluster of ten logic cells, two adders per cell
// Notes: chain entry points are cell indices counted from zero
package sac_pkg;
    // ************************************************************
    // cluster geometry
    // ************************************************************
    localparam int CELLS = 10;
    localparam int ADDERS_PER_CELL = 2;
    localparam int HALF_CELLS = 5;
    localparam int FIRST_START_CELL = 0;
    localparam int SECOND_START_CELL = 5;
    localparam int LUT_INPUTS = 4;
    localparam int CLEAR_LINES = 2;
    // ************************************************************
    // reset values and chain modes
    // ************************************************************
    localparam logic REG_RESET = 1'h0;
    typedef enum logic [1:0] {
        SAC_BYPASS_NONE,
        SAC_BYPASS_TOP,
        SAC_BYPASS_BOTTOM
    } sac_bypass_t;
endpackage

// ### rtl/sac_cell.sv
// Purpose: one logic cell in shared arithmetic mode, two three-input adders
// Assumes: all registers share the cluster gated clock and two clears
// Notes: lookup tables modelled as four 4-input functions per cell
`timescale 1ns/1ps
module sac_cell (
    // clock and clears
    input wire logic gclk,
    input wire logic devClrN,
    input wire logic [1:0] aclr,
    input wire logic [1:0] clrSel,
    // synchronous controls
    input wire logic sclr,
    input wire logic sload,
    input wire logic [1:0] sclrUse,
    input wire logic [1:0] sloadUse,
    input wire logic [1:0] loadData,
    input wire logic [1:0] presetInv,
    // operands, per adder
    input wire logic active,
    input wire logic [1:0] opA,
    input wire logic [1:0] opB,
    input wire logic [1:0] opC,
    input wire logic shareIn,
    input wire logic carryIn,
    // register chain
    input wire logic chainSel,
    input wire logic [1:0] chainIn,
    // results
    output logic [1:0] sumComb,
    output logic [1:0] sumReg,
    output logic shareOut,
    output logic carryOut
);
    // ************************************************************
    // four lookup halves: sum and share terms
    // ************************************************************
    // idle adders see zero operands to save switching
    wire logic [1:0] a = active ? opA : 2'h0;
    wire logic [1:0] b = active ? opB : 2'h0;
    wire logic [1:0] c = active ? opC : 2'h0;
    wire logic [1:0] shIn;
    wire logic [1:0] shTerm;
    wire logic [1:0] lutSum;
    wire logic [1:0] cy;
    assign shIn = {shTerm[0], active ? shareIn : 1'h0};
    assign cy[0] = active ? carryIn : 1'h0;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gAdd
            // three-input sum and carry terms, each a 4-input table
            assign lutSum[g] = a[g] ^ b[g] ^ c[g];
            assign shTerm[g] = (a[g] & b[g]) | (a[g] & c[g]) | (b[g] & c[g]);
            // dedicated adder folds in the previous share term and carry
            assign sumComb[g] = lutSum[g] ^ shIn[g] ^ cy[g];
            if (g == 0) begin : gCy
                assign cy[1] = (lutSum[0] & shIn[0]) | (cy[0] & (lutSum[0] ^ shIn[0]));
            end
        end
    endgenerate
    assign carryOut = (lutSum[1] & shIn[1]) | (cy[1] & (lutSum[1] ^ shIn[1]));
    assign shareOut = shTerm[1];
    // ************************************************************
    // cell registers
    // ************************************************************
    wire logic [1:0] dIn;
    wire logic [1:0] dSync;
    wire logic [1:0] clrHit;
    assign dIn = chainSel ? chainIn : sumComb;
    generate
        for (g = 0; g < 2; g++) begin : gReg
            // each register picks its clear line and obeys controls on its own
            assign clrHit[g] = aclr[clrSel[g]];
            assign dSync[g] = (sclr & sclrUse[g]) ? 1'h0 :
                ((sload & sloadUse[g]) ? loadData[g] : dIn[g]);
            // preset by storing inverted data and inverting the output
            logic q;
            always_ff @(posedge gclk or negedge devClrN or posedge clrHit[g]) begin
                if (!devClrN) begin
                    q <= sac_pkg::REG_RESET;
                end else if (clrHit[g]) begin
                    q <= sac_pkg::REG_RESET;
                end else begin
                    q <= dSync[g] ^ presetInv[g];
                end
            end
            assign sumReg[g] = q ^ presetInv[g];
        end
    endgenerate
endmodule

// ### test/sac_cluster_properties.sv
// Purpose: port-level properties of the shared arithmetic cluster
// Assumes: one clock domain, resetn async active low
// Notes: quiet needs three enabled edges free of clears
`timescale 1ns/1ps
module sac_props #(
    parameter int CELLS = sac_pkg::CELLS
) (
    // clock and clears
    input wire logic ref_clk, resetn, device_wide_clear_n, cluster_clock_enable_one,
    input wire logic [1:0] clusterClr,
    // controls
    input wire logic sclr, sload, startFirst, startSixth, halfBypass,
    input wire logic [2*CELLS-1:0] clrSel, sclrUse, sloadUse, loadData, presetInv,
    input wire logic [CELLS-1:0] cellActive, regChainSel,
    // operands, links and results
    input wire logic [2*CELLS-1:0] opA, opB, opC, sumComb, sumReg,
    input wire logic shareLinkIn, carryLinkIn, regLinkIn, shareLinkOut, carryLinkOut, regLinkOut
);
    // ****
    // helpers
    // ****
    localparam int W = 2 * CELLS;
    logic [1:0] quietCnt;
    logic [W-1:0] opMask;
    wire clr = !device_wide_clear_n || clusterClr != 2'h0;
    wire quiet = quietCnt == 2'h3 && !clr;
    wire plain = quiet && cluster_clock_enable_one && regChainSel == '0;
    wire [W-1:0] hit = (clusterClr[1] ? clrSel : '0) | (clusterClr[0] ? ~clrSel : '0);
    wire [W-1:0] shifted = {sumReg[W-2:0], regLinkIn};
    // flop contents: a preset change moves sumReg with no clock edge
    wire [W-1:0] held = sumReg ^ presetInv;
    wire [W-1:0] stage = sumComb ^ presetInv;
    wire [W-1:0] shiftHeld = shifted ^ presetInv;
    wire [W+1:0] got = {shareLinkOut & carryLinkOut, shareLinkOut ^ carryLinkOut, sumComb};
    wire [W+1:0] total = (W+2)'(opA & opMask) + (opB & opMask) + (opC & opMask);
    // dead cells see zero operands
    always_comb begin
        for (int i = 0; i < W; i++) begin
            opMask[i] = cellActive[i/2];
        end
    end
    // clear release is synchronised, so wait it out
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            quietCnt <= 2'h0;
        end else if (clr) begin
            quietCnt <= 2'h0;
        end else if (cluster_clock_enable_one && quietCnt != 2'h3) begin
            quietCnt <= quietCnt + 2'h1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_dev_clear: assert property (!device_wide_clear_n |-> sumReg == presetInv)
        else $error("device clear missed a register");
    a_line_clear: assert property (((sumReg ^ presetInv) & hit) == '0)
        else $error("line clear missed a register");
    a_hold_off: assert property (!cluster_clock_enable_one && !clr |=>
        clr || held == $past(held)) else $error("register moved with enable low");
    a_capture_sum: assert property (plain && !sclr && !sload |=>
        clr || held == $past(stage)) else $error("sum not captured");
    a_sync_clear: assert property (plain && sclr && presetInv == '0 |=>
        clr || (held & $past(sclrUse)) == '0) else $error("sync clear missed");
    a_sync_load: assert property (plain && sload && !sclr |=> clr ||
        ((held ^ $past(presetInv)) & $past(sloadUse)) == ($past(loadData) & $past(sloadUse)))
        else $error("sync load missed");
    a_chain_shift: assert property (quiet && cluster_clock_enable_one && &regChainSel
        && !sclr && !sload |=> clr || held == $past(shiftHeld)) else $error("bad shift");
    a_reg_link: assert property (regLinkOut == sumReg[W-1])
        else $error("register link out wrong");
    a_sum_start: assert property (startFirst && !startSixth && !halfBypass
        && &cellActive[CELLS-1:1] |-> got == total) else $error("chain sum wrong");
    a_sum_link: assert property (!startFirst && !startSixth && !halfBypass && &cellActive
        |-> got == total + shareLinkIn + carryLinkIn) else $error("linked sum wrong");
    c_dev_load: cover property (!device_wide_clear_n && sload);
    c_chain: cover property (quiet && &regChainSel && cluster_clock_enable_one);
    c_hold: cover property (quiet && !cluster_clock_enable_one);
    c_half_link: cover property (halfBypass && !startSixth && shareLinkIn);
endmodule

// ### test/sac_upstream.sv
// Purpose: cluster above in the column, feeding the link inputs
// Assumes: its last register runs on ref_clk
// Notes: share and carry terms come straight from want, unregistered
`timescale 1ns/1ps
module sac_upstream (
    // clock and wanted link levels
    input wire logic ref_clk,
    input wire logic [2:0] want,
    // links toward the cluster below
    output logic shareOut,
    output logic carryOut,
    output logic regOut
);
    // a register, so the chain bit moves only on edges
    always_ff @(posedge ref_clk) begin
        regOut <= want[2];
    end
    assign shareOut = want[0];
    assign carryOut = want[1];
endmodule

// ### test/tb.sv
// Purpose: self-checking bench for the shared arithmetic cluster
// Assumes: upper cluster modelled, lower cluster absent
// Notes: inputs move on the falling edge
`timescale 1ns/1ps
module tb;
    localparam int W = 2 * sac_pkg::CELLS;
    logic ref_clk = 1'h0, resetn = 1'h0, devN = 1'h1, en = 1'h1, sclr = 1'h0, sload = 1'h0;
    logic first = 1'h1, shareI, carryI, regI, shareO, carryO, regO;
    logic sixth = 1'h0, bypass = 1'h0;
    logic [1:0] clr = 2'h0;
    logic [2:0] want = 3'h0;
    logic [9:0] act = 10'h3ff, chainSel = 10'h0;
    logic [W-1:0] clrSel = '0, sclrUse = '0, sloadUse = '0, loadData = '0, pre = '0;
    logic [W-1:0] a = '0, b = '0, c = '0, sumC, sumR, s;
    logic [W+1:0] e;
    int n_mismatch = 0, checks_done = 0;
    // ****
    // clock, partner and design
    // ****
    initial forever #20 ref_clk = ~ref_clk;
    sac_upstream u_sac_upstream (.ref_clk(ref_clk), .want(want), .shareOut(shareI),
        .carryOut(carryI), .regOut(regI));
    sac_cluster u_sac_cluster (.ref_clk(ref_clk), .resetn(resetn), .device_wide_clear_n(devN),
        .cluster_clock_enable_one(en), .clusterClr(clr), .clrSel(clrSel), .sclr(sclr),
        .sload(sload), .sclrUse(sclrUse), .sloadUse(sloadUse), .loadData(loadData),
        .presetInv(pre), .startFirst(first), .startSixth(sixth), .halfBypass(bypass),
        .cellActive(act), .regChainSel(chainSel), .opA(a), .opB(b), .opC(c),
        .shareLinkIn(shareI), .carryLinkIn(carryI), .regLinkIn(regI), .shareLinkOut(shareO),
        .carryLinkOut(carryO), .regLinkOut(regO), .sumComb(sumC), .sumReg(sumR));
    task automatic chk(input logic [W+1:0] got, input logic [W+1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // sums plain, with dead first cell, and fed from above
    task automatic t_sum();
        logic [W-1:0] tv [0:5];
        logic [W-1:0] m;
        tv = '{20'hfffff, 20'hfffff, 20'hfffff, 20'h12345, 20'haaaaa, 20'h55555};
        for (int k = 0; k < 6; k++) begin
            m = k % 3 == 1 ? 20'hffffc : 20'hfffff;
            act = k % 3 == 1 ? 10'h3fe : 10'h3ff;
            first = k % 3 != 2;
            want = k % 3 == 2 ? 3'h3 : 3'h0;
            a = tv[k/3*3];
            b = tv[k/3*3+1];
            c = tv[k/3*3+2];
            e = (W+2)'(a & m) + (b & m) + (c & m) + (k % 3 == 2 ? 22'h2 : 22'h0);
            #1;
            chk({shareO & carryO, shareO ^ carryO, sumC}, e);
            cyc(1);
            chk(sumR, e[W-1:0]);
        end
        first = 1'h1;
    endtask
    // enable low freezes registers; then sync clear and load
    task automatic t_hold();
        s = sumR;
        en = 1'h0;
        a = 20'h0f0f0;
        cyc(2);
        chk(sumR, s);
        en = 1'h1;
        s = a + b + c;
        cyc(1);
        chk(sumR, s);
        sclr = 1'h1;
        sclrUse = 20'h0f0f0;
        cyc(1);
        chk(sumR, s & ~sclrUse);
        sclr = 1'h0;
        sload = 1'h1;
        sloadUse = 20'hff000;
        loadData = 20'ha5a5a;
        cyc(1);
        chk(sumR, (s & ~sloadUse) | (loadData & sloadUse));
        sload = 1'h0;
        cyc(1);
    endtask
    // line clears with preset by inversion, then device clear over load
    task automatic t_clr();
        pre = 20'h0000f;
        clrSel = 20'h000ff;
        cyc(1);
        clr = 2'h2;
        #1;
        chk(sumR, (s & 20'hfff00) | pre);
        cyc(1);
        chk(sumR, (s & 20'hfff00) | pre);
        clr = 2'h1;
        #1;
        chk(sumR, pre);
        clr = 2'h0;
        devN = 1'h0;
        sload = 1'h1;
        sloadUse = 20'hfffff;
        cyc(1);
        chk(sumR, pre);
        devN = 1'h1;
        sload = 1'h0;
        pre = '0;
        cyc(4);
        chk(sumR, s);
    endtask
    // chain bit from above walks down all twenty registers
    task automatic t_chain();
        chainSel = 10'h3ff;
        want = 3'h4;
        cyc(22);
        chk({regO, sumR}, {1'h1, 20'hfffff});
        want = 3'h0;
        cyc(5);
        chk(sumR, 20'hffff0);
        chainSel = 10'h0;
    endtask
    // top half skipped: link from above enters cell six, a fresh start there ignores it
    task automatic t_half();
        bypass = 1'h1;
        want = 3'h3;
        a = 20'hfffff;
        b = 20'h3c3ff;
        c = 20'h81234;
        for (int k = 0; k < 2; k++) begin
            sixth = k[0];
            e = (W+2)'(a & 20'hffc00) + (b & 20'hffc00) + (c & 20'hffc00) +
                (k == 0 ? 22'h800 : 22'h0);
            #1;
            chk({shareO & carryO, shareO ^ carryO, sumC}, e);
            cyc(1);
            chk(sumR, e[W-1:0]);
        end
        bypass = 1'h0;
        sixth = 1'h0;
        want = 3'h0;
    endtask
    // main sequence
    initial begin
        cyc(2);
        resetn = 1'h1;
        cyc(4);
        t_sum();
        t_hold();
        t_clr();
        t_chain();
        t_half();
        conclude();
    end
    // hang guard, far beyond the run of about fifty-five cycles
    initial begin
        repeat (1000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end
endmodule
bind sac_cluster sac_props #(.CELLS(CELLS)) u_sac_props (.ref_clk(ref_clk), .resetn(resetn),
    .device_wide_clear_n(device_wide_clear_n),
    .cluster_clock_enable_one(cluster_clock_enable_one), .clusterClr(clusterClr),
    .sclr(sclr), .sload(sload), .startFirst(startFirst), .startSixth(startSixth),
    .halfBypass(halfBypass), .clrSel(clrSel), .sclrUse(sclrUse), .sloadUse(sloadUse),
    .loadData(loadData), .presetInv(presetInv), .cellActive(cellActive),
    .regChainSel(regChainSel), .opA(opA), .opB(opB), .opC(opC), .sumComb(sumComb),
    .sumReg(sumReg), .shareLinkIn(shareLinkIn), .carryLinkIn(carryLinkIn),
    .regLinkIn(regLinkIn), .shareLinkOut(shareLinkOut), .carryLinkOut(carryLinkOut),
    .regLinkOut(regLinkOut));
